//--- shared/edq_pkg.sv
/*
 * Package for the DMA status and descriptor-queue register block.
 * Assumes an APB slave with 32-bit data and aligned word registers.
 */
package edq_pkg;

   // Register byte offsets.
   localparam logic [7:0] ADDR_RXQP   = 8'h18;
   localparam logic [7:0] ADDR_TXQP   = 8'h1C;
   localparam logic [7:0] ADDR_RXFLG  = 8'h20;
   localparam logic [7:0] ADDR_INTFLG = 8'h24;
   localparam logic [7:0] ADDR_TXFLG  = 8'h14;
   localparam logic [7:0] ADDR_MASK   = 8'h30;

   // Transmit event flag positions.
   localparam int TXF_OWNED  = 0;
   localparam int TXF_COLL   = 1;
   localparam int TXF_RETRY  = 2;
   localparam int TXF_ACTIVE = 3;
   localparam int TXF_RANOUT = 4;
   localparam int TXF_W      = 5;

   // Receive event flag positions.
   localparam int RXF_NOFREE = 0;
   localparam int RXF_STORED = 1;
   localparam int RXF_FAILED = 2;
   localparam int RXF_W      = 3;

   // Interrupt source flag positions.
   localparam int IRQ_MGMT_DONE   = 0;
   localparam int IRQ_RX_STORED   = 1;
   localparam int IRQ_RX_OWNED    = 2;
   localparam int IRQ_TX_OWNED    = 3;
   localparam int IRQ_TX_UNDERRUN = 4;
   localparam int IRQ_RETRY       = 5;
   localparam int IRQ_TX_EMPTY    = 6;
   localparam int IRQ_TX_DONE     = 7;
   localparam int IRQ_RX_OVERFLOW = 10;
   localparam int IRQ_BUS_ERROR   = 11;
   localparam int IRQ_PAUSE_FRAME = 12;
   localparam int IRQ_PAUSE_DONE  = 13;
   localparam int IRQ_W           = 14;
   localparam logic [IRQ_W-1:0] IRQ_IMPL = 14'h3CFF;
   localparam logic [IRQ_W-1:0] MASK_RESET = 14'h3CFF;

   // Queue pointer geometry.
   localparam int QP_LSB   = 2;
   // Descriptors are two words, so the word pointer moves by two per buffer.
   localparam logic [31:QP_LSB] QP_STEP = 30'h0000_0002;
   localparam int QP_IDX_W = 10;
   localparam logic [QP_IDX_W-1:0] QP_IDX_LAST = 10'h3FF;

   // Hardware events from the DMA and MAC, one-cycle pulses or levels.
   typedef struct packed {
      logic tx_active;
      logic tx_ran_out;
      logic tx_retry;
      logic tx_collision;
      logic tx_owned_seen;
      logic tx_frame_done;
      logic tx_underrun;
      logic tx_buf_used;
      logic tx_buf_wrap;
      logic tx_frame_start;
      logic rx_failed;
      logic rx_stored;
      logic rx_no_free;
      logic rx_owned_seen;
      logic rx_buf_used;
      logic rx_buf_wrap;
      logic bus_error;
      logic pause_frame;
      logic pause_done;
      logic mgmt_done;
   } edq_evt_t;

endpackage

//--- hw/edq_regs.sv
/*
 * DMA status and descriptor-queue pointer registers with APB access.
 * Assumes the DMA engine reports its events on the event struct in the
 * pclk domain and reads the queue pointers to address descriptors.
 */
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps

module edq_regs
   import edq_pkg::*;
(
   // Clock and reset.
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // DMA side.
   input  wire edq_evt_t    evt,
   output logic      [31:0] rx_queue_ptr,
   output logic      [31:0] tx_queue_ptr,
   output logic             irq
);

   logic                wr_en;
   logic                rd_en;
   logic                mapped;
   logic [TXF_W-1:0]    tx_flags_reg;
   logic [RXF_W-1:0]    rx_flags_reg;
   logic [IRQ_W-1:0]    int_flags_reg;
   logic [IRQ_W-1:0]    int_flags_next;
   logic [IRQ_W-1:0]    mask_reg;
   logic [IRQ_W-1:0]    hw_evt;
   logic [31:QP_LSB]    rx_start_reg;
   logic [31:QP_LSB]    rx_cur_reg;
   logic [QP_IDX_W-1:0] rx_cnt_reg;
   logic [31:QP_LSB]    tx_start_reg;
   logic [31:QP_LSB]    tx_cur_reg;
   logic [31:QP_LSB]    tx_frame_reg;
   logic [QP_IDX_W-1:0] tx_cnt_reg;
   logic                tx_active_reg;
   logic                tx_ptr_wr;
   logic                rx_ptr_wr;

   // Steps a queue pointer, returning to the start on wrap or after the
   // last of 1024 entries.
   function automatic logic [31:QP_LSB] qp_step(
      input logic [31:QP_LSB]    cur,
      input logic [31:QP_LSB]    start,
      input logic [QP_IDX_W-1:0] cnt,
      input logic                wrap
   );
      if (wrap || cnt == QP_IDX_LAST) begin
         qp_step = start;
      end else begin
         qp_step = cur + QP_STEP;
      end
   endfunction

   function automatic logic [QP_IDX_W-1:0] cnt_step(
      input logic [QP_IDX_W-1:0] cnt,
      input logic                wrap
   );
      cnt_step = wrap ? '0 : cnt + 10'h001;
   endfunction

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign mapped = paddr == ADDR_RXQP || paddr == ADDR_TXQP ||
                   paddr == ADDR_RXFLG || paddr == ADDR_INTFLG ||
                   paddr == ADDR_TXFLG || paddr == ADDR_MASK;
   // Loading a new queue while it runs would tear the descriptor walk.
   assign tx_ptr_wr = wr_en && paddr == ADDR_TXQP && !tx_active_reg;
   assign rx_ptr_wr = wr_en && paddr == ADDR_RXQP;

   // The slave answers in its first access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
      end
   end

   // Read data is staged in the setup cycle; the read-clear of the
   // interrupt flags happens at the access edge.  The staged flags include
   // events taken at the setup edge, so the later clear drops none unseen.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            ADDR_RXQP:   prdata <= {rx_cur_reg, 2'b00};
            ADDR_TXQP:   prdata <= {tx_frame_reg, 2'b00};
            ADDR_RXFLG:  prdata <= {29'h0, rx_flags_reg};
            ADDR_TXFLG:  prdata <= {27'h0, tx_flags_reg};
            ADDR_INTFLG: prdata <= {18'h0, int_flags_next | hw_evt};
            ADDR_MASK:   prdata <= {18'h0, mask_reg};
            default:     prdata <= '0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_active_reg <= 1'b0;
      end else begin
         tx_active_reg <= evt.tx_active;
      end
   end

   // Transmit event flags; bit 3 mirrors the live transmitter state.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_flags_reg <= '0;
      end else begin
         if (wr_en && paddr == ADDR_TXFLG) begin
            tx_flags_reg <= tx_flags_reg & ~pwdata[TXF_W-1:0];
         end
         if (evt.tx_ran_out) tx_flags_reg[TXF_RANOUT] <= 1'b1;
         if (evt.tx_retry) tx_flags_reg[TXF_RETRY] <= 1'b1;
         if (evt.tx_collision) tx_flags_reg[TXF_COLL] <= 1'b1;
         if (evt.tx_owned_seen) tx_flags_reg[TXF_OWNED] <= 1'b1;
         tx_flags_reg[TXF_ACTIVE] <= evt.tx_active;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_flags_reg <= '0;
      end else begin
         if (wr_en && paddr == ADDR_RXFLG) begin
            rx_flags_reg <= rx_flags_reg & ~pwdata[RXF_W-1:0];
         end
         if (evt.rx_failed) rx_flags_reg[RXF_FAILED] <= 1'b1;
         if (evt.rx_stored) rx_flags_reg[RXF_STORED] <= 1'b1;
         if (evt.rx_no_free) rx_flags_reg[RXF_NOFREE] <= 1'b1;
      end
   end

   // Receive pointer; start bit 2 alignment is left to software.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_start_reg <= '0;
         rx_cur_reg   <= '0;
         rx_cnt_reg   <= '0;
      end else if (rx_ptr_wr) begin
         rx_start_reg <= pwdata[31:QP_LSB];
         rx_cur_reg   <= pwdata[31:QP_LSB];
         rx_cnt_reg   <= '0;
      end else if (evt.rx_buf_used) begin
         rx_cur_reg <= qp_step(rx_cur_reg, rx_start_reg, rx_cnt_reg,
                               evt.rx_buf_wrap);
         rx_cnt_reg <= cnt_step(rx_cnt_reg,
                                evt.rx_buf_wrap || rx_cnt_reg == QP_IDX_LAST);
      end
   end

   // Transmit pointer; the frame pointer latches the first buffer.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_start_reg <= '0;
         tx_cur_reg   <= '0;
         tx_frame_reg <= '0;
         tx_cnt_reg   <= '0;
      end else if (tx_ptr_wr) begin
         tx_start_reg <= pwdata[31:QP_LSB];
         tx_cur_reg   <= pwdata[31:QP_LSB];
         tx_frame_reg <= pwdata[31:QP_LSB];
         tx_cnt_reg   <= '0;
      end else begin
         if (evt.tx_buf_used) begin
            tx_cur_reg <= qp_step(tx_cur_reg, tx_start_reg, tx_cnt_reg,
                                  evt.tx_buf_wrap);
            tx_cnt_reg <= cnt_step(tx_cnt_reg,
                            evt.tx_buf_wrap || tx_cnt_reg == QP_IDX_LAST);
         end
         if (evt.tx_frame_start) tx_frame_reg <= tx_cur_reg;
      end
   end

   always_comb begin
      hw_evt = '0;
      hw_evt[IRQ_MGMT_DONE]   = evt.mgmt_done;
      hw_evt[IRQ_RX_STORED]   = evt.rx_stored;
      hw_evt[IRQ_RX_OWNED]    = evt.rx_owned_seen;
      hw_evt[IRQ_TX_OWNED]    = evt.tx_owned_seen;
      hw_evt[IRQ_TX_UNDERRUN] = evt.tx_underrun || tx_ptr_wr;
      hw_evt[IRQ_RETRY]       = evt.tx_retry;
      hw_evt[IRQ_TX_EMPTY]    = evt.tx_ran_out;
      hw_evt[IRQ_TX_DONE]     = evt.tx_frame_done;
      hw_evt[IRQ_RX_OVERFLOW] = evt.rx_failed;
      hw_evt[IRQ_BUS_ERROR]   = evt.bus_error;
      hw_evt[IRQ_PAUSE_FRAME] = evt.pause_frame;
      hw_evt[IRQ_PAUSE_DONE]  = evt.pause_done;
      hw_evt = hw_evt & ~mask_reg & IRQ_IMPL;
   end

   // A read clears everything; a write loads the flags directly for test.
   always_comb begin
      int_flags_next = int_flags_reg;
      if (rd_en && paddr == ADDR_INTFLG) begin
         int_flags_next = '0;
      end else if (wr_en && paddr == ADDR_INTFLG) begin
         int_flags_next = pwdata[IRQ_W-1:0] & IRQ_IMPL;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_flags_reg <= '0;
      end else begin
         int_flags_reg <= int_flags_next | hw_evt;
      end
   end

   // Mask: write one masks, write zero unmasks; reads show the mask.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_reg <= MASK_RESET;
      end else if (wr_en && paddr == ADDR_MASK) begin
         mask_reg <= pwdata[IRQ_W-1:0] & IRQ_IMPL;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq          <= 1'b0;
         rx_queue_ptr <= '0;
         tx_queue_ptr <= '0;
      end else begin
         irq          <= |int_flags_reg;
         rx_queue_ptr <= {rx_cur_reg, 2'b00};
         tx_queue_ptr <= {tx_cur_reg, 2'b00};
      end
   end

   property p_tx_w1c;
      @(posedge pclk) disable iff (!presetn)
      (wr_en && paddr == ADDR_TXFLG && pwdata[TXF_COLL] && !evt.tx_collision)
      |=> !tx_flags_reg[TXF_COLL];
   endproperty
   a_tx_w1c: assert property (p_tx_w1c)
      else $error("collision flag not cleared by write one");

   property p_tx_ranout;
      @(posedge pclk) disable iff (!presetn)
      evt.tx_ran_out |=> tx_flags_reg[TXF_RANOUT];
   endproperty
   a_tx_ranout: assert property (p_tx_ranout)
      else $error("ran-out flag not set");

   property p_tx_active;
      @(posedge pclk) disable iff (!presetn)
      tx_flags_reg[TXF_ACTIVE] == $past(evt.tx_active);
   endproperty
   a_tx_active: assert property (p_tx_active)
      else $error("active flag does not follow transmitter");

   property p_rx_store;
      @(posedge pclk) disable iff (!presetn)
      evt.rx_failed |=> rx_flags_reg[RXF_FAILED];
   endproperty
   a_rx_store: assert property (p_rx_store)
      else $error("store-failed flag not set");

   property p_rx_noset;
      @(posedge pclk) disable iff (!presetn)
      (!evt.rx_no_free && !evt.rx_stored && !evt.rx_failed)
      |=> (rx_flags_reg & ~$past(rx_flags_reg)) == '0;
   endproperty
   a_rx_noset: assert property (p_rx_noset)
      else $error("receive flag set without an event");

   property p_txqp_lock;
      @(posedge pclk) disable iff (!presetn)
      (tx_active_reg && !evt.tx_buf_used && !evt.tx_frame_start)
      |=> $stable(tx_start_reg);
   endproperty
   a_txqp_lock: assert property (p_txqp_lock)
      else $error("transmit pointer changed while active");

   property p_irq_line;
      @(posedge pclk) disable iff (!presetn)
      (|int_flags_reg) |=> irq;
   endproperty
   a_irq_line: assert property (p_irq_line)
      else $error("interrupt not raised for a set flag");

   property p_masked;
      @(posedge pclk) disable iff (!presetn)
      (mask_reg[IRQ_BUS_ERROR] && !wr_en && !int_flags_reg[IRQ_BUS_ERROR])
      |=> !int_flags_reg[IRQ_BUS_ERROR];
   endproperty
   a_masked: assert property (p_masked)
      else $error("masked source set its flag");

   property p_rdclr;
      @(posedge pclk) disable iff (!presetn)
      (rd_en && paddr == ADDR_INTFLG && hw_evt == '0)
      |=> int_flags_reg == '0;
   endproperty
   a_rdclr: assert property (p_rdclr)
      else $error("interrupt flags not cleared by read");

   property p_resv;
      @(posedge pclk) disable iff (!presetn)
      (int_flags_reg & ~IRQ_IMPL) == '0;
   endproperty
   a_resv: assert property (p_resv)
      else $error("reserved interrupt bit set");

   property p_rx_wrap;
      @(posedge pclk) disable iff (!presetn)
      (evt.rx_buf_used && evt.rx_buf_wrap && !rx_ptr_wr)
      |=> rx_cur_reg == $past(rx_start_reg);
   endproperty
   a_rx_wrap: assert property (p_rx_wrap)
      else $error("receive pointer did not wrap");

   property p_rx_step;
      @(posedge pclk) disable iff (!presetn)
      (evt.rx_buf_used && !evt.rx_buf_wrap && !rx_ptr_wr &&
       rx_cnt_reg != QP_IDX_LAST)
      |=> rx_cur_reg == $past(rx_cur_reg) + QP_STEP;
   endproperty
   a_rx_step: assert property (p_rx_step)
      else $error("receive pointer did not step one descriptor");

   property p_rx_last;
      @(posedge pclk) disable iff (!presetn)
      (evt.rx_buf_used && rx_cnt_reg == QP_IDX_LAST && !rx_ptr_wr)
      |=> rx_cur_reg == $past(rx_start_reg);
   endproperty
   a_rx_last: assert property (p_rx_last)
      else $error("receive pointer did not return after the last entry");

   property p_tx_wrap;
      @(posedge pclk) disable iff (!presetn)
      (evt.tx_buf_used && evt.tx_buf_wrap && !tx_ptr_wr)
      |=> tx_cur_reg == $past(tx_start_reg);
   endproperty
   a_tx_wrap: assert property (p_tx_wrap)
      else $error("transmit pointer did not wrap");

   property p_irq_clear;
      @(posedge pclk) disable iff (!presetn)
      (int_flags_reg == '0) |=> !irq;
   endproperty
   a_irq_clear: assert property (p_irq_clear)
      else $error("interrupt raised with no flag set");

endmodule

//--- test/edq_dma_model.sv
/*
 * Stand-in for the DMA engine beside the register block: turns bench
 * requests into event pulses and the transmit-active level.
 * Assumes everything runs on pclk.
 */
`timescale 1ns/1ps
module edq_dma_model
   import edq_pkg::*;
(
   // Clock and reset.
   input  wire logic     pclk,
   input  wire logic     presetn,
   // Bench requests.
   input  wire edq_evt_t req,
   input  wire logic     tx_busy,
   // Events to the block.
   output edq_evt_t      evt
);
   // Registered, so each request lands as a clean pulse one clock later.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt <= '0;
      end else begin
         evt           <= req;
         evt.tx_active <= tx_busy;
      end
   end
endmodule

//--- test/edq_regs_tb.sv
/*
 * Self-checking bench for the status and queue pointer registers.
 * Assumes the APB slave answers without wait states and the DMA stand-in
 * delays every event request by one clock.
 */
`timescale 1ns/1ps
module edq_regs_tb
   import edq_pkg::*;
;
   // Byte step per descriptor, since descriptors are two words.
   localparam int DESC = 8;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        irq, tx_busy;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rxp, txp, s;
   edq_evt_t    req, evt, ev;
   logic [32:0] expq[$];
   int          num_errors, checks, i;
   int          fl_pos[7] = '{15, 16, 17, 18, 7, 8, 9};
   int          fl_bit[7] = '{0, 1, 2, 4, 0, 1, 2};
   int          ev_pos[12] = '{0, 8, 6, 15, 13, 17, 18, 14, 9, 3, 2, 1};
   int          ir_bit[12] = '{0, 1, 2, 3, 4, 5, 6, 7, 10, 11, 12, 13};

   edq_regs edq_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
      .rx_queue_ptr(rxp), .tx_queue_ptr(txp), .irq(irq));
   edq_dma_model edq_dma_model_i (.pclk(pclk), .presetn(presetn),
      .req(req), .tx_busy(tx_busy), .evt(evt));

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task conclude;
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task cmp_bus(input logic [32:0] g, input logic [32:0] e);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   task cmp_out(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
            input edq_evt_t evq, input logic [32:0] e);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      req     <= evq;
      expq.push_back(e);
      @(posedge pclk);
      penable <= 1'b1;
      req     <= '0;
      for (n = 0; n < 20 && !pready; n++)
         @(posedge pclk);
      if (!pready) begin
         num_errors++;
         conclude();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, '0, 33'h0);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, '0, {1'b0, e});
   endtask

   task pulse(input edq_evt_t p);
      @(posedge pclk);
      req <= p;
      @(posedge pclk);
      req <= '0;
   endtask

   task idle(input int k);
      repeat (k) @(posedge pclk);
   endtask

   // Read and write results are compared when the access completes.
   always @(posedge pclk) begin
      if (psel && penable && pready)
         cmp_bus(pwrite ? {pslverr, 32'h0} : {pslverr, prdata},
                 expq.pop_front());
   end

   initial begin
      #1_000_000;
      num_errors++;
      conclude();
   end

   initial begin
      {psel, penable, pwrite, tx_busy} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      req = '0;
      presetn = 1'b0;
      void'($urandom(32'h2C2B));
      idle(6);
      presetn <= 1'b1;
      rd(ADDR_RXQP, 32'h0);
      rd(ADDR_TXQP, 32'h0);
      rd(ADDR_RXFLG, 32'h0);
      rd(ADDR_TXFLG, 32'h0);
      rd(ADDR_MASK, 32'h3CFF);
      apb(1'b0, 8'h04, 32'h0, '0, {1'b1, 32'h0});
      apb(1'b1, 8'h08, 32'hFFFFFFFF, '0, {1'b1, 32'h0});
      // Each flag alone: set, survive a write of 0, not set by 1s, clear.
      for (i = 0; i < 7; i++) begin
         ev = '0;
         ev[fl_pos[i]] = 1'b1;
         pulse(ev);
         s = (i < 4) ? {24'h0, ADDR_TXFLG} : {24'h0, ADDR_RXFLG};
         rd(s[7:0], 32'h1 << fl_bit[i]);
         wr(s[7:0], ~(32'h1 << fl_bit[i]));
         rd(s[7:0], 32'h1 << fl_bit[i]);
         wr(s[7:0], 32'h1 << fl_bit[i]);
         rd(s[7:0], 32'h0);
      end
      rd(ADDR_INTFLG, 32'h0);
      tx_busy <= 1'b1;
      idle(3);
      rd(ADDR_TXFLG, 32'h8);
      wr(ADDR_TXQP, 32'h00005000);
      rd(ADDR_TXQP, 32'h0);
      tx_busy <= 1'b0;
      idle(3);
      rd(ADDR_TXFLG, 32'h0);
      s = $urandom & 32'hFFFFFFF8;
      wr(ADDR_RXQP, s | 32'h3);
      rd(ADDR_RXQP, s);
      ev = '0;
      ev.rx_buf_used = 1'b1;
      pulse(ev);
      idle(3);
      cmp_out(rxp, s + DESC);
      rd(ADDR_RXQP, s + DESC);
      repeat (1023) pulse(ev);
      idle(3);
      cmp_out(rxp, s);
      pulse(ev);
      ev.rx_buf_wrap = 1'b1;
      pulse(ev);
      idle(3);
      cmp_out(rxp, s);
      s = $urandom & 32'hFFFFFFF8;
      wr(ADDR_TXQP, s);
      rd(ADDR_TXQP, s);
      ev = '0;
      ev.tx_frame_start = 1'b1;
      pulse(ev);
      ev = '0;
      ev.tx_buf_used = 1'b1;
      pulse(ev);
      pulse(ev);
      idle(3);
      cmp_out(txp, s + 2 * DESC);
      rd(ADDR_TXQP, s);
      repeat (1022) pulse(ev);
      idle(3);
      cmp_out(txp, s);
      pulse(ev);
      // A frame starting on the second buffer moves the frame pointer.
      ev = '0;
      ev.tx_frame_start = 1'b1;
      pulse(ev);
      rd(ADDR_TXQP, s + DESC);
      ev = '0;
      ev.tx_buf_used = 1'b1;
      ev.tx_buf_wrap = 1'b1;
      pulse(ev);
      idle(3);
      cmp_out(txp, s);
      rd(ADDR_TXQP, s + DESC);
      wr(ADDR_MASK, 32'h0);
      for (i = 0; i < 12; i++) begin
         ev = '0;
         ev[ev_pos[i]] = 1'b1;
         pulse(ev);
         idle(4);
         cmp_out({31'h0, irq}, 32'h1);
         rd(ADDR_INTFLG, 32'h1 << ir_bit[i]);
         rd(ADDR_INTFLG, 32'h0);
         idle(2);
         cmp_out({31'h0, irq}, 32'h0);
      end
      wr(ADDR_TXQP, s);
      rd(ADDR_INTFLG, 32'h10);
      ev = '0;
      ev.bus_error = 1'b1;
      apb(1'b0, ADDR_INTFLG, 32'h0, ev, 33'h0);
      rd(ADDR_INTFLG, 32'h800);
      wr(ADDR_MASK, 32'h3CFF);
      pulse(ev);
      idle(3);
      rd(ADDR_INTFLG, 32'h0);
      wr(ADDR_INTFLG, 32'hFFFFFFFF);
      idle(3);
      cmp_out({31'h0, irq}, 32'h1);
      rd(ADDR_INTFLG, 32'h3CFF);
      wr(ADDR_INTFLG, 32'h5);
      wr(ADDR_INTFLG, 32'h1);
      rd(ADDR_INTFLG, 32'h1);
      conclude();
   end
endmodule
